// File: core/sbrc_pkg.sv
/*
  Constants, register map and field layout of the serial backplane receiver
  control block. Assumes a single 100 MHz register/control clock.
*/
package sbrc_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] SBRC_ADDR_CTRL = 8'h00;
   localparam logic [7:0] SBRC_ADDR_GPC = 8'h04;
   localparam logic [7:0] SBRC_ADDR_STATUS = 8'h08;
   localparam logic [7:0] SBRC_ADDR_CHANGE = 8'h0c;
   localparam logic [7:0] SBRC_ADDR_MASK = 8'h10;
   localparam logic [7:0] SBRC_ADDR_DATA = 8'h14;
   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_QRATE = 0;
   localparam int CTRL_BYPASS = 1;
   localparam int CTRL_TERM = 2;
   localparam int CTRL_REFSEL_LO = 4;
   localparam int CTRL_EQ_LO = 8;
   localparam int CTRL_LOSTH_LO = 12;
   localparam logic [1:0] REFSEL_DIV8 = 2'h0;
   localparam logic [1:0] REFSEL_DIV16 = 2'h1;
   localparam logic [1:0] REFSEL_DIV32 = 2'h2;
   localparam logic [1:0] REFSEL_RST = REFSEL_DIV16;
   localparam logic [3:0] EQ_RST = 4'h0;
   localparam logic [1:0] LOSTH_RST = 2'h1;
   localparam logic TERM_RST = 1'b0;
   // ----------------------------------------------------------------
   // general control bits
   // ----------------------------------------------------------------
   localparam int GPC_PPM_LO = 0;
   localparam int GPC_FORCE_REF = 2;
   localparam int GPC_FORCE_DATA = 3;
   localparam logic [7:0] GPC_RST = 8'h00;
   // ----------------------------------------------------------------
   // status, change and mask bits
   // ----------------------------------------------------------------
   localparam int ST_LOL = 0;
   localparam int ST_LOLHI = 1;
   localparam int ST_LOLLO = 2;
   localparam int ST_LOS = 3;
   localparam int ST_NOREF = 4;
   localparam int ST_TRACK = 5;
   localparam int CHG_LOL = 0;
   localparam int CHG_LOS = 1;
   localparam int CHG_W = 2;
   // ----------------------------------------------------------------
   // lock tolerance in ppm, loss of signal thresholds in mV
   // ----------------------------------------------------------------
   localparam int PPM_1000 = 1000;
   localparam int PPM_2000 = 2000;
   localparam int PPM_8000 = 8000;
   localparam int PPM_16000 = 16000;
   localparam int PPM_SCALE = 1000000;
   localparam int NOREF_CYCLES = 4;
   localparam logic [7:0] LOS_SET_01 = 8'd15;
   localparam logic [7:0] LOS_CLR_01 = 8'd70;
   localparam logic [7:0] LOS_SET_10 = 8'd60;
   localparam logic [7:0] LOS_CLR_10 = 8'd100;
   localparam logic [7:0] LOS_SET_11 = 8'd95;
   localparam logic [7:0] LOS_CLR_11 = 8'd150;
   // ----------------------------------------------------------------
   // deserializer timing and AXI response codes
   // ----------------------------------------------------------------
   localparam logic [1:0] QR_CENTER = 2'd2;
   localparam logic [2:0] BYTE_LAST = 3'd7;
   localparam logic [4:0] QR_BYTE_LAST = 5'd31;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [0:0] {
      SBRC_ACQ_REF = 1'b0,
      SBRC_TRACK_DATA = 1'b1
   } sbrc_acq_t;
endpackage : sbrc_pkg

// File: core/sbrc_top.sv
/*
  Serial backplane receiver control: deserializer with quarter-rate byte
  repetition, reference-based lock detector, loss of reference and loss of
  signal monitors, and an AXI4-Lite register slave with change interrupt.
  Assumes the serial bit strobe, recovered data, reference clock and signal
  level arrive from the analog front end asynchronously to i_clk and are far
  slower than i_clk (behavioural model of the link).
*/
//
// Function
// (R1) quarter rate: each deserialized byte is output four times at normal byte rate
// (R2) software picks rate per channel; all channels must share one rate
// (R3) 8-bit word with byte tick every eight bit clocks, also in quarter rate
// (R4) quarter rate samples one bit per four clocks, at the centre clock
// (R5) lock detector compares divided clock with reference; flags high or low
// (R6) lock lost equals high OR low; all three readable in status
// (R7) out of tolerance: acquire reference first, then return to data tracking
// (R8) control bit 2 forces reference lock, bit 3 keeps data detector engaged
// (R9) 2-bit tolerance field selects assert and deassert ppm thresholds
// (R10) no reference edge within four divided cycles declares loss of reference
// (R11) deserializer divider has asynchronous master reset to a known state
// (R12) bypass uses reference clock directly as the bit clock
// (R13) 2-bit ratio field selects reference at 1/8, 1/16 or 1/32 rate
// (R14) 4-bit equalization field drives input equalization strength
// (R15) termination bit 1 selects supply termination, 0 floating differential
// (R16) amplitude below selected threshold asserts readable loss of signal
// (R17) lock lost and loss of signal have change flags and masks
// (R18) front-end signals are synchronized before status or flags use them
`timescale 1ns/100ps
module sbrc_top
   import sbrc_pkg::*;
#(
   parameter int REF_WIN = 8192,
   parameter int ADDR_W = 8
)(
   // clock and resets
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_master_resetn,
   // analog front end
   input wire logic i_bit_clk,
   input wire logic i_ser_data,
   input wire logic i_ref_clk,
   input wire logic [7:0] i_sig_level_mv,
   // front end controls
   output logic o_quarter_rate_select,
   output logic o_pll_bypass,
   output logic o_input_termination_select,
   output logic [1:0] o_refsel,
   output logic [3:0] o_eq_ctrl,
   output logic o_ref_lock_sel,
   output logic o_data_pd_en,
   // byte stream to receive framer
   output logic [7:0] o_byte,
   output logic o_byte_en,
   // interrupt
   output logic o_irq,
   // axi4-lite slave
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);
   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic [31:0] tol_cnt(input logic [31:0] expct, input int ppm);
      tol_cnt = 32'((64'(expct) * 64'(ppm)) / 64'(PPM_SCALE));
   endfunction : tol_cnt

   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      addr_is = (8'(a) == off);
   endfunction : addr_is

   // ----------------------------------------------------------------
   // front end synchronizers
   // ----------------------------------------------------------------
   logic [2:0] bit_clk_ff, ser_data_ff, ref_clk_ff;
   logic [7:0] lvl_s1_ff, lvl_ff;
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         bit_clk_ff <= 3'h0;
         ser_data_ff <= 3'h0;
         ref_clk_ff <= 3'h0;
         lvl_s1_ff <= 8'h00;
         lvl_ff <= 8'h00;
      end
      else
      begin
         bit_clk_ff <= {bit_clk_ff[1:0], i_bit_clk}; // see (R18)
         ser_data_ff <= {ser_data_ff[1:0], i_ser_data};
         ref_clk_ff <= {ref_clk_ff[1:0], i_ref_clk};
         lvl_s1_ff <= i_sig_level_mv;
         lvl_ff <= lvl_s1_ff;
      end
   end
   logic ref_edge, rec_edge, bit_edge, ser_bit;
   assign ref_edge = ref_clk_ff[1] & ~ref_clk_ff[2];
   assign rec_edge = bit_clk_ff[1] & ~bit_clk_ff[2];
   assign ser_bit = ser_data_ff[1];

   // ----------------------------------------------------------------
   // registers written by software
   // ----------------------------------------------------------------
   logic qrate_ff, bypass_ff, term_ff;
   logic [1:0] refsel_ff, losth_ff;
   logic [3:0] eq_ff;
   logic [7:0] gpc_ff;
   logic [CHG_W-1:0] mask_ff;
   assign bit_edge = bypass_ff ? ref_edge : rec_edge; // see (R12)

   // ----------------------------------------------------------------
   // deserializer
   // ----------------------------------------------------------------
   logic [4:0] div_ff;
   logic [7:0] shift_ff, hold_ff;
   logic byte_tick, qr_sample, qr_done;
   assign byte_tick = bit_edge && (div_ff[2:0] == BYTE_LAST); // see (R3)
   assign qr_sample = bit_edge && (div_ff[1:0] == QR_CENTER); // see (R4)
   assign qr_done = bit_edge && (div_ff == QR_BYTE_LAST);

   always_ff @(posedge i_clk or negedge i_master_resetn)
   begin
      if (!i_master_resetn)
         div_ff <= 5'h00; // see (R11)
      else if (!i_resetn)
         div_ff <= 5'h00;
      else if (bit_edge)
         div_ff <= div_ff + 5'h01;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         shift_ff <= 8'h00;
      else if (qrate_ff ? qr_sample : bit_edge)
         shift_ff <= {shift_ff[6:0], ser_bit};
   end

   // full rate: new byte every tick; quarter rate: byte held for four ticks
   logic [7:0] nxt_byte;
   always_comb
   begin
      nxt_byte = hold_ff;
      if (!qrate_ff)
         nxt_byte = {shift_ff[6:0], ser_bit};
      else if (qr_done)
         nxt_byte = shift_ff; // see (R1)
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         hold_ff <= 8'h00;
         o_byte <= 8'h00;
         o_byte_en <= 1'b0;
      end
      else
      begin
         o_byte_en <= byte_tick; // see (R3)
         if (byte_tick)
         begin
            hold_ff <= nxt_byte;
            o_byte <= nxt_byte; // see (R1)
         end
      end
   end

   // ----------------------------------------------------------------
   // loss of reference
   // ----------------------------------------------------------------
   logic [2:0] gap_ff;
   logic noref_ff;
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         gap_ff <= 3'h0;
         noref_ff <= 1'b0;
      end
      else if (ref_edge)
      begin
         gap_ff <= 3'h0;
         noref_ff <= 1'b0;
      end
      else if (byte_tick && gap_ff < 3'(NOREF_CYCLES))
         gap_ff <= gap_ff + 3'h1;
      else if (gap_ff >= 3'(NOREF_CYCLES))
         noref_ff <= 1'b1; // see (R10)
   end

   // ----------------------------------------------------------------
   // lock detector
   // ----------------------------------------------------------------
   logic [31:0] win_ff, div_cnt_ff, expct, tol_on, tol_off, diff;
   logic locked_ff, lolhi_ff, lollo_ff, fast;
   always_comb
   begin
      unique case (refsel_ff) // see (R13)
         REFSEL_DIV8: expct = 32'(REF_WIN);
         REFSEL_DIV32: expct = 32'(REF_WIN) << 2;
         default: expct = 32'(REF_WIN) << 1;
      endcase
      unique case (gpc_ff[GPC_PPM_LO+:2]) // see (R9)
         2'h1:
         begin
            tol_on = tol_cnt(expct, PPM_1000);
            tol_off = tol_cnt(expct, PPM_16000);
         end
         2'h2:
         begin
            tol_on = tol_cnt(expct, PPM_2000);
            tol_off = tol_cnt(expct, PPM_16000);
         end
         default:
         begin
            tol_on = tol_cnt(expct, PPM_1000);
            tol_off = tol_cnt(expct, PPM_8000);
         end
      endcase
      fast = div_cnt_ff > expct;
      diff = fast ? div_cnt_ff - expct : expct - div_cnt_ff;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn || noref_ff)
      begin
         win_ff <= 32'h0;
         div_cnt_ff <= 32'h0;
      end
      else if (ref_edge && win_ff == 32'(REF_WIN - 1))
      begin
         win_ff <= 32'h0;
         div_cnt_ff <= 32'(byte_tick);
      end
      else
      begin
         if (ref_edge)
            win_ff <= win_ff + 32'h1;
         if (byte_tick)
            div_cnt_ff <= div_cnt_ff + 32'h1;
      end
   end

   wire logic win_end = ref_edge && win_ff == 32'(REF_WIN - 1);
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         locked_ff <= 1'b0;
         lolhi_ff <= 1'b0;
         lollo_ff <= 1'b0;
      end
      else if (noref_ff)
      begin
         locked_ff <= 1'b0;
         lolhi_ff <= 1'b1;
         lollo_ff <= 1'b0;
      end
      else if (win_end)
      begin
         if (locked_ff ? diff > tol_off : diff > tol_on)
         begin
            locked_ff <= 1'b0;
            lolhi_ff <= fast; // see (R5)
            lollo_ff <= !fast;
         end
         else
         begin
            locked_ff <= 1'b1;
            lolhi_ff <= 1'b0;
            lollo_ff <= 1'b0;
         end
      end
   end
   wire logic lol = lolhi_ff | lollo_ff; // see (R6)

   // ----------------------------------------------------------------
   // acquisition sequencing
   // ----------------------------------------------------------------
   sbrc_acq_t acq_ff;
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         acq_ff <= SBRC_ACQ_REF;
      else
         unique case (acq_ff)
            SBRC_ACQ_REF: if (locked_ff) acq_ff <= SBRC_TRACK_DATA;
            SBRC_TRACK_DATA: if (!locked_ff) acq_ff <= SBRC_ACQ_REF; // see (R7)
         endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_ref_lock_sel <= 1'b1;
         o_data_pd_en <= 1'b0;
      end
      else
      begin
         o_ref_lock_sel <= (acq_ff == SBRC_ACQ_REF) | gpc_ff[GPC_FORCE_REF]; // see (R8)
         o_data_pd_en <= (acq_ff == SBRC_TRACK_DATA) | gpc_ff[GPC_FORCE_DATA]; // see (R8)
      end
   end

   // ----------------------------------------------------------------
   // loss of signal with hysteresis
   // ----------------------------------------------------------------
   logic los_ff;
   logic [7:0] los_set, los_clr;
   always_comb
   begin
      unique case (losth_ff)
         2'h1:
         begin
            los_set = LOS_SET_01;
            los_clr = LOS_CLR_01;
         end
         2'h2:
         begin
            los_set = LOS_SET_10;
            los_clr = LOS_CLR_10;
         end
         default:
         begin
            los_set = LOS_SET_11;
            los_clr = LOS_CLR_11;
         end
      endcase
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn || losth_ff == 2'h0)
         los_ff <= 1'b0;
      else if (lvl_ff < los_set)
         los_ff <= 1'b1; // see (R16)
      else if (lvl_ff > los_clr)
         los_ff <= 1'b0;
   end

   // ----------------------------------------------------------------
   // change flags and interrupt
   // ----------------------------------------------------------------
   logic lol_d_ff, los_d_ff;
   logic [CHG_W-1:0] chg_ff, chg_set;
   logic rd_chg;
   assign chg_set = {los_ff ^ los_d_ff, lol ^ lol_d_ff}; // see (R17)
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         lol_d_ff <= 1'b0;
         los_d_ff <= 1'b0;
         chg_ff <= '0;
         o_irq <= 1'b0;
      end
      else
      begin
         lol_d_ff <= lol;
         los_d_ff <= los_ff;
         chg_ff <= (rd_chg ? '0 : chg_ff) | chg_set; // see (R17)
         o_irq <= |(((rd_chg ? '0 : chg_ff) | chg_set) & mask_ff);
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   logic aw_got_ff, w_got_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic do_wr;
   assign do_wr = aw_got_ff && w_got_ff && !o_bvalid;
   assign o_awready = !aw_got_ff && !o_bvalid;
   assign o_wready = !w_got_ff && !o_bvalid;
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= AXI_OKAY;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            w_got_ff <= 1'b1;
            wdata_ff <= i_wdata;
            wstrb_ff <= i_wstrb;
         end
         if (do_wr)
         begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= (addr_is(awaddr_ff, SBRC_ADDR_CTRL) || addr_is(awaddr_ff, SBRC_ADDR_GPC)
                        || addr_is(awaddr_ff, SBRC_ADDR_MASK)) ? AXI_OKAY : AXI_SLVERR;
         end
         else if (o_bvalid && i_bready)
            o_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         qrate_ff <= 1'b0;
         bypass_ff <= 1'b0;
         term_ff <= TERM_RST;
         refsel_ff <= REFSEL_RST;
         eq_ff <= EQ_RST;
         losth_ff <= LOSTH_RST;
         gpc_ff <= GPC_RST;
         mask_ff <= '0;
      end
      else if (do_wr)
      begin
         if (addr_is(awaddr_ff, SBRC_ADDR_CTRL) && wstrb_ff[0])
         begin
            qrate_ff <= wdata_ff[CTRL_QRATE]; // see (R2)
            bypass_ff <= wdata_ff[CTRL_BYPASS];
            term_ff <= wdata_ff[CTRL_TERM];
            refsel_ff <= wdata_ff[CTRL_REFSEL_LO+:2];
         end
         if (addr_is(awaddr_ff, SBRC_ADDR_CTRL) && wstrb_ff[1])
         begin
            eq_ff <= wdata_ff[CTRL_EQ_LO+:4];
            losth_ff <= wdata_ff[CTRL_LOSTH_LO+:2];
         end
         if (addr_is(awaddr_ff, SBRC_ADDR_GPC) && wstrb_ff[0])
            gpc_ff <= wdata_ff[7:0];
         if (addr_is(awaddr_ff, SBRC_ADDR_MASK) && wstrb_ff[0])
            mask_ff <= wdata_ff[CHG_W-1:0];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_quarter_rate_select <= 1'b0;
         o_pll_bypass <= 1'b0;
         o_input_termination_select <= TERM_RST;
         o_refsel <= REFSEL_RST;
         o_eq_ctrl <= EQ_RST;
      end
      else
      begin
         o_quarter_rate_select <= qrate_ff; // see (R4)
         o_pll_bypass <= bypass_ff; // see (R12)
         o_input_termination_select <= term_ff; // see (R15)
         o_refsel <= refsel_ff; // see (R13)
         o_eq_ctrl <= eq_ff; // see (R14)
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   logic [31:0] rd_val;
   logic rd_ok;
   assign o_arready = !o_rvalid;
   assign rd_chg = i_arvalid && o_arready && addr_is(i_araddr, SBRC_ADDR_CHANGE);
   always_comb
   begin
      rd_val = 32'h0;
      rd_ok = 1'b1;
      if (addr_is(i_araddr, SBRC_ADDR_CTRL))
      begin
         rd_val[CTRL_QRATE] = qrate_ff;
         rd_val[CTRL_BYPASS] = bypass_ff;
         rd_val[CTRL_TERM] = term_ff;
         rd_val[CTRL_REFSEL_LO+:2] = refsel_ff;
         rd_val[CTRL_EQ_LO+:4] = eq_ff;
         rd_val[CTRL_LOSTH_LO+:2] = losth_ff;
      end
      else if (addr_is(i_araddr, SBRC_ADDR_GPC))
         rd_val[7:0] = gpc_ff;
      else if (addr_is(i_araddr, SBRC_ADDR_STATUS))
      begin
         rd_val[ST_LOL] = lol; // see (R6)
         rd_val[ST_LOLHI] = lolhi_ff;
         rd_val[ST_LOLLO] = lollo_ff;
         rd_val[ST_LOS] = los_ff; // see (R16)
         rd_val[ST_NOREF] = noref_ff; // see (R10)
         rd_val[ST_TRACK] = (acq_ff == SBRC_TRACK_DATA);
      end
      else if (addr_is(i_araddr, SBRC_ADDR_CHANGE))
         rd_val[CHG_W-1:0] = chg_ff;
      else if (addr_is(i_araddr, SBRC_ADDR_MASK))
         rd_val[CHG_W-1:0] = mask_ff;
      else if (addr_is(i_araddr, SBRC_ADDR_DATA))
         rd_val[7:0] = hold_ff;
      else
         rd_ok = 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0;
         o_rresp <= AXI_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         o_rvalid <= 1'b1;
         o_rdata <= rd_val;
         o_rresp <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      end
      else if (o_rvalid && i_rready)
         o_rvalid <= 1'b0;
   end
endmodule : sbrc_top

// File: tb/sbrc_properties.sv
/* port checker for sbrc_top; assumes one clock and the sync reset i_resetn */
`timescale 1ns/100ps
module sbrc_properties (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // watched ports
   input wire logic o_byte_en,
   input wire logic o_ref_lock_sel,
   input wire logic o_data_pd_en,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic i_rready
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_wr_taken;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   a_byte_gap: assert property (o_byte_en |=> !o_byte_en [*8]) else $error("tick gap");
   a_lock_mode: assert property (o_ref_lock_sel || o_data_pd_en) else $error("no loop");
   a_wr_answer: assert property (s_wr_taken |=> ##[0:1] o_bvalid) else $error("no b");
   a_wr_hold: assert property (o_bvalid && !i_bready |=> o_bvalid) else $error("b drop");
   a_wr_block: assert property (o_bvalid |-> !o_awready && !o_wready) else $error("aw");
   a_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("no r");
   a_rd_hold: assert property (o_rvalid && !i_rready |=> o_rvalid) else $error("r drop");
   a_rd_block: assert property (o_rvalid |-> !o_arready) else $error("ar");
endmodule : sbrc_properties
bind sbrc_top sbrc_properties sbrc_properties_i (.i_clk, .i_resetn, .o_byte_en, .o_ref_lock_sel,
   .o_data_pd_en, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_bready,
   .i_arvalid, .o_arready, .o_rvalid, .i_rready);

// File: tb/sbrc_far_end.sv
/* far-end transmitter model; drives the serial and reference pins of sbrc_top */
`timescale 1ns/100ps
module sbrc_far_end (
   // serial pins
   output logic o_bit_clk = 1'b0,
   output logic o_ser_data = 1'b0,
   output logic o_ref_clk = 1'b0,
   // reference enable
   input wire logic i_ref_on
);
   always #50 if (i_ref_on) o_ref_clk = !o_ref_clk;
   // bit clock stands still between frames; data shows the inverse once released
   task automatic send(input logic [7:0] b, input int k);
      for (int n = 0; n < 8 * k; n++)
      begin
         o_ser_data = b[7 - n / k];
         #40 o_bit_clk = 1'b1;
         #40 o_bit_clk = 1'b0;
      end
      o_ser_data = !o_ser_data;
   endtask : send
endmodule : sbrc_far_end

// File: tb/sbrc_bench.sv
/* bench for sbrc_top; far end modelled by sbrc_far_end */
`timescale 1ns/100ps
module sbrc_bench
   import sbrc_pkg::*;
;
   logic i_clk, i_bit_clk, i_ser_data, i_ref_clk, o_quarter_rate_select, o_pll_bypass;
   logic o_input_termination_select, o_ref_lock_sel, o_data_pd_en, o_byte_en, o_irq;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_rready = 1'b0;
   logic i_resetn = 1'b0, i_master_resetn = 1'b0, ref_on = 1'b1, i_awvalid = 1'b0;
   logic i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0;
   logic [7:0] o_byte, i_sig_level_mv = 8'h64, i_awaddr = 8'h00, i_araddr = 8'h00;
   logic [1:0] o_refsel, o_bresp, o_rresp;
   logic [3:0] o_eq_ctrl, i_wstrb = 4'hf;
   logic [31:0] o_rdata, i_wdata = 32'h0;
   int compares = 0, miscompares = 0;
   sbrc_top #(.REF_WIN(64)) sbrc_top_i (.i_clk, .i_resetn, .i_master_resetn, .i_bit_clk,
      .i_ser_data, .i_ref_clk, .i_sig_level_mv, .o_quarter_rate_select, .o_pll_bypass,
      .o_input_termination_select, .o_refsel, .o_eq_ctrl, .o_ref_lock_sel, .o_data_pd_en,
      .o_byte, .o_byte_en, .o_irq, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
      .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
      .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
   sbrc_far_end sbrc_far_end_i (.o_bit_clk(i_bit_clk), .o_ser_data(i_ser_data),
      .o_ref_clk(i_ref_clk), .i_ref_on(ref_on));
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = !i_clk;
   end
   initial
   begin
      #200000;
      miscompares++;
      close_out();
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         miscompares++;
         $display("[ERR] t=%0t got %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   // idle slave takes address and data together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do @(posedge i_clk); while (!(o_awready === 1'b1 && o_wready === 1'b1));
      i_awvalid <= 1'b0;
      i_wvalid <= 1'b0;
      do @(posedge i_clk); while (o_bvalid !== 1'b1);
      i_bready <= 1'b0;
      chk(o_bresp, r);
      @(posedge i_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do @(posedge i_clk); while (o_arready !== 1'b1);
      i_arvalid <= 1'b0;
      do @(posedge i_clk); while (o_rvalid !== 1'b1);
      i_rready <= 1'b0;
      d = o_rdata;
      chk(o_rresp, r);
   endtask : rd
   task automatic t_regs();
      logic [31:0] d;
      rd(SBRC_ADDR_CTRL, d, AXI_OKAY);
      chk(d, 32'h1010);
      for (int i = 0; i < 3; i++)
      begin
         wr(SBRC_ADDR_CTRL, 32'h1000 | i << 4 | 5 * i << 8 | i << 2 & 4, AXI_OKAY);
         chk(o_refsel, i);
         chk(o_eq_ctrl, 5 * i);
         chk(o_input_termination_select, i & 1);
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(SBRC_ADDR_GPC, i | 32'hc, AXI_OKAY);
         rd(SBRC_ADDR_GPC, d, AXI_OKAY);
         chk(d, i | 32'hc);
         chk({o_ref_lock_sel, o_data_pd_en}, 2'h3);
      end
      wr(SBRC_ADDR_GPC, 32'h0, AXI_OKAY);
      wr(SBRC_ADDR_STATUS, 32'h0, AXI_SLVERR);
      rd(8'h18, d, AXI_SLVERR);
      chk(d, 32'h0);
      wr(SBRC_ADDR_CTRL, 32'h1010, AXI_OKAY);
      $display("regs done");
   endtask : t_regs
   task automatic t_stream();
      logic [31:0] d;
      int n = 0;
      fork
         sbrc_far_end_i.send(8'ha5, 1);
         do @(posedge i_clk); while (o_byte_en !== 1'b1);
      join
      chk(o_byte, 8'ha5);
      rd(SBRC_ADDR_DATA, d, AXI_OKAY);
      chk(d, 32'ha5);
      wr(SBRC_ADDR_CTRL, 32'h1012, AXI_OKAY);
      chk(o_pll_bypass, 1'b1);
      repeat (300) @(posedge i_clk) n += o_byte_en;
      chk(n > 1, 1'b1);
      wr(SBRC_ADDR_CTRL, 32'h1011, AXI_OKAY);
      chk(o_quarter_rate_select, 1'b1);
      // bypass left the divider at an odd phase; master reset realigns it
      i_master_resetn <= 1'b0;
      @(posedge i_clk);
      i_master_resetn <= 1'b1;
      fork
         repeat (2) sbrc_far_end_i.send(8'h5a, 4);
         for (int k = 1; k < 9; k++)
         begin
            do @(posedge i_clk); while (o_byte_en !== 1'b1);
            if (k > 4) chk(o_byte, 8'h5a);
         end
      join
      wr(SBRC_ADDR_CTRL, 32'h1010, AXI_OKAY);
      $display("stream done");
   endtask : t_stream
   task automatic t_alarms();
      logic [31:0] d;
      wr(SBRC_ADDR_MASK, 32'h2, AXI_OKAY);
      rd(SBRC_ADDR_CHANGE, d, AXI_OKAY);
      i_sig_level_mv <= 8'h0a;
      repeat (8) @(posedge i_clk);
      chk(o_irq, 1'b1);
      rd(SBRC_ADDR_STATUS, d, AXI_OKAY);
      chk(d[3], 1'b1);
      wr(SBRC_ADDR_MASK, 32'h0, AXI_OKAY);
      chk(o_irq, 1'b0);
      rd(SBRC_ADDR_CHANGE, d, AXI_OKAY);
      chk(d[1], 1'b1);
      i_sig_level_mv <= 8'h64;
      repeat (8) @(posedge i_clk);
      chk(o_irq, 1'b0);
      rd(SBRC_ADDR_CHANGE, d, AXI_OKAY);
      chk(d[1], 1'b1);
      ref_on <= 1'b0;
      repeat (5) sbrc_far_end_i.send(8'h00, 1);
      rd(SBRC_ADDR_STATUS, d, AXI_OKAY);
      chk(d & 32'h13, 32'h13);
      ref_on <= 1'b1;
      repeat (30) @(posedge i_clk);
      rd(SBRC_ADDR_STATUS, d, AXI_OKAY);
      chk(d[4], 1'b0);
      $display("alarms done");
   endtask : t_alarms
   initial
   begin
      repeat (16) @(posedge i_clk);
      i_resetn <= 1'b1;
      i_master_resetn <= 1'b1;
      t_regs();
      t_stream();
      t_alarms();
      close_out();
   end
endmodule : sbrc_bench
